/* cbta_pkg.sv */
/*
  Shared constants and types for the cell-balance timer and fault block.
  Assumes a 125 MHz system clock; all timing counts derive from its period.
*/
package cbta_pkg;

  // Channel counts and widths
  localparam int unsigned NUM_CH    = 6;
  localparam int unsigned RES_W     = 12;
  localparam int unsigned THR_W     = 8;
  localparam int unsigned TMR_W     = 5;
  localparam int unsigned ADDR_W    = 5;
  localparam int unsigned DATA_W    = 8;

  // Register addresses
  localparam logic [ADDR_W-1:0] ADDR_CONTROL_HI   = 5'h0d;
  localparam logic [ADDR_W-1:0] ADDR_OVER_VOLT    = 5'h0f;
  localparam logic [ADDR_W-1:0] ADDR_UNDER_VOLT   = 5'h10;
  localparam logic [ADDR_W-1:0] ADDR_OVER_TEMP    = 5'h11;
  localparam logic [ADDR_W-1:0] ADDR_UNDER_TEMP   = 5'h12;
  localparam logic [ADDR_W-1:0] ADDR_FAULT_CFG    = 5'h13;
  localparam logic [ADDR_W-1:0] ADDR_BAL_ENABLE   = 5'h14;
  localparam logic [ADDR_W-1:0] ADDR_BAL_TMR_1    = 5'h15;
  localparam logic [ADDR_W-1:0] ADDR_BAL_TMR_6    = 5'h1a;
  localparam logic [ADDR_W-1:0] ADDR_PWRDN_TMR    = 5'h1b;

  // Reset values
  localparam logic [DATA_W-1:0] RST_REG8          = 8'h00;
  localparam logic [TMR_W-1:0]  RST_TMR           = 5'h00;

  // Field positions
  localparam int unsigned CTRL_SW_PWRDN_BIT = 0;  // D8 sits in bit 0 of the upper control byte
  localparam int unsigned FCFG_ROLE_LSB     = 6;
  localparam int unsigned FCFG_FREQ_LSB     = 4;
  localparam int unsigned FCFG_VEXC_LSB     = 2;
  localparam int unsigned FCFG_TEXC_LSB     = 0;

  // Field encodings
  localparam logic [1:0] ROLE_NONE   = 2'h0;
  localparam logic [1:0] ROLE_STATIC = 2'h1;
  localparam logic [1:0] ROLE_SQUARE = 2'h2;
  localparam logic [1:0] ROLE_PASS   = 2'h3;
  localparam logic [1:0] FREQ_100HZ  = 2'h0;
  localparam logic [1:0] FREQ_1KHZ   = 2'h1;
  localparam logic [1:0] EXC_ONE     = 2'h1;
  localparam logic [1:0] EXC_TWO     = 2'h2;

  // Channels dropped by the exclusion codes (zero based)
  localparam int unsigned VEXC_FIRST = 4;  // cell_input_5
  localparam int unsigned VEXC_SECOND = 3; // cell_input_4
  localparam int unsigned TEXC_FIRST = 4;  // temperature_input_5
  localparam int unsigned TEXC_SECOND = 2; // temperature_input_3

  // Conversion result kinds
  localparam logic [1:0] KIND_VOLT     = 2'h0;
  localparam logic [1:0] KIND_TEMP     = 2'h1;
  localparam logic [1:0] KIND_SELFTEST = 2'h2;

  // Timer limits in minutes
  localparam logic [TMR_W-1:0] BAL_MAX_MIN   = 5'h1e;
  localparam logic [TMR_W-1:0] PWRDN_MAX_MIN = 5'h1f;

  // Timing, in ns, and the derived cycle counts
  localparam longint unsigned CLK_PERIOD_NS  = 64'd8;
  localparam longint unsigned MINUTE_NS      = 64'd60_000_000_000;
  localparam longint unsigned SQ100_HALF_NS  = 64'd5_000_000;
  localparam longint unsigned SQ1K_HALF_NS   = 64'd500_000;
  localparam longint unsigned MINUTE_CYCLES  = MINUTE_NS / CLK_PERIOD_NS;
  localparam longint unsigned SQ100_HALF_CYC = SQ100_HALF_NS / CLK_PERIOD_NS;
  localparam longint unsigned SQ1K_HALF_CYC  = SQ1K_HALF_NS / CLK_PERIOD_NS;

  // Power sequencing states
  typedef enum logic [1:0] {PWR_ACTIVE, PWR_DELAY, PWR_DOWN} cbta_pwr_state_t;

  // Register access request, one cycle per access
  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } cbta_reg_req_t;

  // One conversion result, valid for one cycle
  typedef struct packed {
    logic             valid;
    logic [1:0]       kind;
    logic [2:0]       idx;
    logic [RES_W-1:0] data;
  } cbta_conv_t;

endpackage : cbta_pkg

/* cbta_cell_balance_fault.sv */
/*
  Cell-balance on-time timers, power-down delay and fault output logic.
  Assumes register accesses and conversion results arrive synchronous to
  sys_clk_in, already decoded from the serial link by the surrounding device.
*/
// Functional notes
// - Six balance timers, one per output
// - Timer range 0 to 30 minutes
// - Expiry turns all six outputs off
// - Balance timers reset to zero
// - Zero delay: trigger powers down immediately
// - Nonzero delay: outputs hold until elapsed
// - Compare each conversion against thresholds unless powered down
// - Four threshold registers, flag out-of-range results
// - Static mode: high idle, low on fault
// - Square mode at 100Hz or 1kHz
// - Chain: forward upstream or pull low
// - Master presents chain fault to host; here the chain only feeds fault_out
// - Config bits 7:6 select output role
// - Config bits 3:2 drop voltage channels
// - Config bits 1:0 drop temperature channels
// - Self-test result checked against both voltage thresholds
// - Power-down delay 0 to 31 minutes
// - Balance-enable register, zero after reset
`timescale 1ns/1ps
module cbta_cell_balance_fault #(
  parameter longint unsigned MINUTE_CYC = cbta_pkg::MINUTE_CYCLES,
  parameter longint unsigned SQ100_CYC  = cbta_pkg::SQ100_HALF_CYC,
  parameter longint unsigned SQ1K_CYC   = cbta_pkg::SQ1K_HALF_CYC
) (
  input  wire logic                                sys_clk_in,
  input  wire logic                                reset_n_in,
  input  wire cbta_pkg::cbta_reg_req_t             reg_req_in,
  output logic [cbta_pkg::DATA_W-1:0]              reg_rdata_out,
  input  wire cbta_pkg::cbta_conv_t                conv_in,
  input  wire logic                                powerdown_pin_n_in,
  input  wire logic                                fault_chain_in,
  output logic [cbta_pkg::NUM_CH-1:0]              balancing_gate_output_out,
  output logic                                     fault_out,
  output logic                                     fault_detected_out,
  output logic                                     powered_down_out
);
  import cbta_pkg::*;

  localparam logic [35:0] MIN_LAST   = 36'(MINUTE_CYC - 64'd1);
  localparam logic [19:0] SQ100_LAST = 20'(SQ100_CYC - 64'd1);
  localparam logic [19:0] SQ1K_LAST  = 20'(SQ1K_CYC - 64'd1);

  // Saturate a written minute count at the timer's limit
  function automatic logic [TMR_W-1:0] clamp_min(input logic [DATA_W-1:0] v,
                                                 input logic [TMR_W-1:0]  lim);
    clamp_min = (v > {3'h0, lim}) ? lim : v[TMR_W-1:0];
  endfunction : clamp_min

  // Result outside [lo, hi]; thresholds compare with the top eight result bits
  function automatic logic out_of_range(input logic [RES_W-1:0] d,
                                        input logic [THR_W-1:0] hi,
                                        input logic [THR_W-1:0] lo);
    out_of_range = (d[RES_W-1 -: THR_W] > hi) || (d[RES_W-1 -: THR_W] < lo);
  endfunction : out_of_range

  // Registers
  logic [DATA_W-1:0]  ctrl_hi_r, ov_thr_r, uv_thr_r, ot_thr_r, ut_thr_r, fcfg_r;
  logic [NUM_CH-1:0]  bal_en_r;
  logic [TMR_W-1:0]   bal_tmr_r [NUM_CH];
  logic [TMR_W-1:0]   bal_rem_r [NUM_CH];
  logic [TMR_W-1:0]   pwrdn_tmr_r, pwrdn_rem_r;
  logic [35:0]        min_cnt_r;
  logic [19:0]        sq_cnt_r;
  logic               sq_phase_r;
  logic               pin_prev_r;
  logic [NUM_CH-1:0]  viol_v_r, viol_t_r;
  logic               viol_st_r;
  cbta_pwr_state_t    pwr_state_r, pwr_state_nxt;
  logic [DATA_W-1:0]  rdata_nxt;
  logic               fault_out_nxt;

  // Access decode
  wire                wr_ctrl   = reg_req_in.wr && (reg_req_in.addr == ADDR_CONTROL_HI);
  wire                wr_bal    = reg_req_in.wr && (reg_req_in.addr == ADDR_BAL_ENABLE);
  wire                wr_pdt    = reg_req_in.wr && (reg_req_in.addr == ADDR_PWRDN_TMR);
  wire                in_btmr   = (reg_req_in.addr >= ADDR_BAL_TMR_1) &&
                                  (reg_req_in.addr <= ADDR_BAL_TMR_6);
  wire [2:0]          btmr_idx  = 3'(reg_req_in.addr - ADDR_BAL_TMR_1);
  wire                wr_btmr   = reg_req_in.wr && in_btmr;

  // Minute tick shared by every timer
  wire                tick      = (min_cnt_r == MIN_LAST);

  // Power-down triggers: pin falling edge or software bit written as one
  wire                pin_fall  = pin_prev_r && !powerdown_pin_n_in;
  wire                pin_rise  = !pin_prev_r && powerdown_pin_n_in;
  wire                pd_trig   = pin_fall || (wr_ctrl && reg_req_in.wdata[CTRL_SW_PWRDN_BIT]);
  wire                pd_wake   = pin_rise || (wr_ctrl && !reg_req_in.wdata[CTRL_SW_PWRDN_BIT]);
  wire                is_down   = (pwr_state_r == PWR_DOWN);
  wire                go_down   = (pwr_state_nxt == PWR_DOWN) && !is_down;

  // Balance expiry: any programmed timer of an enabled output running out ends all balancing
  logic [NUM_CH-1:0]  bal_expire;
  always_comb
  begin
    for (int i = 0; i < NUM_CH; i++)
    begin
      bal_expire[i] = tick && bal_en_r[i] && (bal_tmr_r[i] != RST_TMR) &&
                      (bal_rem_r[i] == 5'h01);
    end
  end
  wire                bal_stop  = (|bal_expire) || go_down;

  // Channel exclusion masks
  wire [1:0]          vexc      = fcfg_r[FCFG_VEXC_LSB +: 2];
  wire [1:0]          texc      = fcfg_r[FCFG_TEXC_LSB +: 2];
  logic [NUM_CH-1:0]  vmask, tmask;
  always_comb
  begin
    vmask = '1;
    tmask = '1;
    if ((vexc == EXC_ONE) || (vexc == EXC_TWO))
    begin
      vmask[VEXC_FIRST] = 1'b0;
    end
    if (vexc == EXC_TWO)
    begin
      vmask[VEXC_SECOND] = 1'b0;
    end
    if ((texc == EXC_ONE) || (texc == EXC_TWO))
    begin
      tmask[TEXC_FIRST] = 1'b0;
    end
    if (texc == EXC_TWO)
    begin
      tmask[TEXC_SECOND] = 1'b0;
    end
  end

  // Conversion compare; results are dropped while powered down
  wire                conv_ok   = conv_in.valid && !is_down && (conv_in.idx < 3'(NUM_CH));
  wire                v_bad     = out_of_range(conv_in.data, ov_thr_r, uv_thr_r);
  wire                t_bad     = out_of_range(conv_in.data, ot_thr_r, ut_thr_r);
  wire                fault_now = (|(viol_v_r & vmask)) || (|(viol_t_r & tmask)) || viol_st_r;

  // Output role and square-wave pacing
  wire [1:0]          role      = fcfg_r[FCFG_ROLE_LSB +: 2];
  wire [1:0]          freq      = fcfg_r[FCFG_FREQ_LSB +: 2];
  wire                freq_ok   = (freq == FREQ_100HZ) || (freq == FREQ_1KHZ);
  wire [19:0]         sq_last   = (freq == FREQ_1KHZ) ? SQ1K_LAST : SQ100_LAST;
  // Wrap at or past the limit, so a rate change mid-count never runs the counter long
  wire                sq_wrap   = (sq_cnt_r >= sq_last);

  // Output role select; reserved frequency codes leave the line low
  always_comb
  begin
    case (role)
      ROLE_STATIC: fault_out_nxt = !fault_now;
      ROLE_SQUARE: fault_out_nxt = freq_ok && !fault_now && sq_phase_r;
      ROLE_PASS:   fault_out_nxt = fault_chain_in && !fault_now;
      default:     fault_out_nxt = 1'b0;
    endcase
  end

  // Power sequencing
  always_comb
  begin
    pwr_state_nxt = pwr_state_r;
    case (pwr_state_r)
      PWR_ACTIVE:
      begin
        if (pd_trig)
        begin
          pwr_state_nxt = (pwrdn_tmr_r == RST_TMR) ? PWR_DOWN : PWR_DELAY;
        end
      end
      PWR_DELAY:
      begin
        if (pd_wake)
        begin
          pwr_state_nxt = PWR_ACTIVE;
        end
        else if (tick && (pwrdn_rem_r == 5'h01))
        begin
          pwr_state_nxt = PWR_DOWN;
        end
      end
      PWR_DOWN:
      begin
        if (pd_wake)
        begin
          pwr_state_nxt = PWR_ACTIVE;
        end
      end
      default: pwr_state_nxt = PWR_ACTIVE;
    endcase
  end

  // Read mux, registered on a read strobe
  always_comb
  begin
    rdata_nxt = reg_rdata_out;
    if (reg_req_in.rd)
    begin
      case (reg_req_in.addr)
        ADDR_CONTROL_HI: rdata_nxt = ctrl_hi_r;
        ADDR_OVER_VOLT:  rdata_nxt = ov_thr_r;
        ADDR_UNDER_VOLT: rdata_nxt = uv_thr_r;
        ADDR_OVER_TEMP:  rdata_nxt = ot_thr_r;
        ADDR_UNDER_TEMP: rdata_nxt = ut_thr_r;
        ADDR_FAULT_CFG:  rdata_nxt = fcfg_r;
        ADDR_BAL_ENABLE: rdata_nxt = {2'h0, bal_en_r};
        ADDR_PWRDN_TMR:  rdata_nxt = {3'h0, pwrdn_tmr_r};
        default:         rdata_nxt = in_btmr ? {3'h0, bal_tmr_r[btmr_idx]} : RST_REG8;
      endcase
    end
  end

  // Configuration registers
  always_ff @(posedge sys_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      ctrl_hi_r   <= RST_REG8;
      ov_thr_r    <= RST_REG8;
      uv_thr_r    <= RST_REG8;
      ot_thr_r    <= RST_REG8;
      ut_thr_r    <= RST_REG8;
      fcfg_r      <= RST_REG8;
      pwrdn_tmr_r <= RST_TMR;
    end
    else if (reg_req_in.wr)
    begin
      case (reg_req_in.addr)
        ADDR_CONTROL_HI: ctrl_hi_r   <= reg_req_in.wdata;
        ADDR_OVER_VOLT:  ov_thr_r    <= reg_req_in.wdata;
        ADDR_UNDER_VOLT: uv_thr_r    <= reg_req_in.wdata;
        ADDR_OVER_TEMP:  ot_thr_r    <= reg_req_in.wdata;
        ADDR_UNDER_TEMP: ut_thr_r    <= reg_req_in.wdata;
        ADDR_FAULT_CFG:  fcfg_r      <= reg_req_in.wdata;
        ADDR_PWRDN_TMR:  pwrdn_tmr_r <= clamp_min(reg_req_in.wdata, PWRDN_MAX_MIN);
        default:         ;
      endcase
    end
  end

  // Balance timers and their running remainders
  always_ff @(posedge sys_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      for (int i = 0; i < NUM_CH; i++)
      begin
        bal_tmr_r[i] <= RST_TMR;
        bal_rem_r[i] <= RST_TMR;
      end
    end
    else
    begin
      for (int i = 0; i < NUM_CH; i++)
      begin
        if (wr_btmr && (btmr_idx == 3'(i)))
        begin
          bal_tmr_r[i] <= clamp_min(reg_req_in.wdata, BAL_MAX_MIN);
        end
        if (wr_bal && !is_down)
        begin
          bal_rem_r[i] <= bal_tmr_r[i];
        end
        else if (tick && (bal_rem_r[i] != RST_TMR))
        begin
          bal_rem_r[i] <= bal_rem_r[i] - 5'h01;
        end
      end
    end
  end

  // Balance enables; stopping wins over a write in the same cycle for safety
  always_ff @(posedge sys_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      bal_en_r <= '0;
    end
    else if (bal_stop)
    begin
      bal_en_r <= '0;
    end
    else if (wr_bal && !is_down)
    begin
      bal_en_r <= reg_req_in.wdata[NUM_CH-1:0];
    end
  end

  // Power state, delay countdown, minute prescaler
  always_ff @(posedge sys_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      pwr_state_r <= PWR_ACTIVE;
      pwrdn_rem_r <= RST_TMR;
      pin_prev_r  <= 1'b1;
      min_cnt_r   <= '0;
    end
    else
    begin
      pwr_state_r <= pwr_state_nxt;
      pin_prev_r  <= powerdown_pin_n_in;
      min_cnt_r   <= tick ? '0 : min_cnt_r + 36'h1;
      if ((pwr_state_r == PWR_ACTIVE) && pd_trig)
      begin
        pwrdn_rem_r <= pwrdn_tmr_r;
      end
      else if (tick && (pwrdn_rem_r != RST_TMR))
      begin
        pwrdn_rem_r <= pwrdn_rem_r - 5'h01;
      end
    end
  end

  // Per-channel violation memory, refreshed by each new result
  always_ff @(posedge sys_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      viol_v_r  <= '0;
      viol_t_r  <= '0;
      viol_st_r <= 1'b0;
    end
    else if (conv_ok)
    begin
      case (conv_in.kind)
        KIND_VOLT:     viol_v_r[conv_in.idx] <= v_bad;
        KIND_TEMP:     viol_t_r[conv_in.idx] <= t_bad;
        KIND_SELFTEST: viol_st_r             <= v_bad;
        default:       ;
      endcase
    end
  end

  // Square-wave generator and registered outputs
  always_ff @(posedge sys_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      sq_cnt_r           <= '0;
      sq_phase_r         <= 1'b0;
      fault_out          <= 1'b0;
      fault_detected_out <= 1'b0;
      powered_down_out   <= 1'b0;
      reg_rdata_out      <= RST_REG8;
    end
    else
    begin
      sq_cnt_r           <= (sq_wrap || (role != ROLE_SQUARE)) ? '0 : sq_cnt_r + 20'h1;
      sq_phase_r         <= (role != ROLE_SQUARE) ? 1'b0 : (sq_phase_r ^ sq_wrap);
      fault_out          <= fault_out_nxt;
      fault_detected_out <= fault_now;
      powered_down_out   <= (pwr_state_nxt == PWR_DOWN);
      reg_rdata_out      <= rdata_nxt;
    end
  end

  assign balancing_gate_output_out = bal_en_r;

endmodule : cbta_cell_balance_fault

/* cbta_chk.sv */
/*
  Assertion checker for the balance timer and fault block.
  Sees only the top ports; bound from the bench top file.
*/
`timescale 1ns/1ps
module cbta_chk (
  input  wire logic                          sys_clk_in,
  input  wire logic                          reset_n_in,
  input  wire cbta_pkg::cbta_reg_req_t       reg_req_in,
  input  wire logic                          powerdown_pin_n_in,
  input  wire logic                          fault_chain_in,
  input  wire logic [cbta_pkg::NUM_CH-1:0]   balancing_gate_output_out,
  input  wire logic                          fault_out,
  input  wire logic                          fault_detected_out,
  input  wire logic                          powered_down_out
);
  import cbta_pkg::*;
  logic [7:0] cfg_r;   // Shadow of the fault config
  logic [7:0] cfg_q_r; // Config one edge earlier
  logic       pdz_r;   // Delay timer written as zero
  wire        wr_w = reg_req_in.wr;
  wire  [4:0] a_w  = reg_req_in.addr;
  wire  [1:0] role = cfg_r[7:6];
  wire        held = cfg_r == cfg_q_r;

  // Outputs lag a config change by one edge, so only judge a settled config
  always_ff @(posedge sys_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      cfg_r   <= 8'h00;
      cfg_q_r <= 8'h00;
      pdz_r   <= 1'b1;
    end
    else
    begin
      if (wr_w && a_w == ADDR_FAULT_CFG) cfg_r <= reg_req_in.wdata;
      if (wr_w && a_w == ADDR_PWRDN_TMR) pdz_r <= reg_req_in.wdata == 8'h00;
      cfg_q_r <= cfg_r;
    end
  end

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!reset_n_in);

  // Outputs move only on an enable write, or fall to zero on a stop
  bal_hold_a: assert property (
    !(wr_w && a_w == ADDR_BAL_ENABLE) |=> $stable(balancing_gate_output_out)
      || balancing_gate_output_out == '0) else $error("balancing outputs moved unasked");
  bal_wr_a: assert property (
    wr_w && a_w == ADDR_BAL_ENABLE && !powered_down_out |=> balancing_gate_output_out
      == $past(reg_req_in.wdata[5:0]) || balancing_gate_output_out == '0)
    else $error("balance enable write not applied");
  pd_off_a: assert property (
    powered_down_out |-> balancing_gate_output_out == '0) else $error("balancing on while down");
  sw_down_a: assert property (
    wr_w && a_w == ADDR_CONTROL_HI && reg_req_in.wdata[0] && pdz_r && !powered_down_out
      |=> powered_down_out) else $error("software power-down not immediate");
  pin_down_a: assert property (
    $fell(powerdown_pin_n_in) && pdz_r && !powered_down_out |=> powered_down_out)
    else $error("pin power-down not immediate");
  static_out_a: assert property (
    role == ROLE_STATIC && held |-> fault_out == !fault_detected_out)
    else $error("static fault level wrong");
  pass_out_a: assert property (
    role == ROLE_PASS && held |-> fault_out == ($past(fault_chain_in) && !fault_detected_out))
    else $error("chain pass-through wrong");
  quiet_out_a: assert property (
    held && (role == ROLE_NONE || (role == ROLE_SQUARE && (cfg_r[5] || fault_detected_out)))
      |-> !fault_out) else $error("fault output not low");

  cover property (role == ROLE_STATIC && fault_detected_out);
  cover property (role == ROLE_PASS && fault_chain_in);
  cover property ($rose(powered_down_out));
endmodule : cbta_chk

/* cbta_upper_dev.sv */
/*
  Upper neighbour in the fault chain, as seen by the block's chain input.
  Runs on the bench clock; pass-through of a further device is not modelled.
*/
`timescale 1ns/1ps
module cbta_upper_dev #(
  parameter int unsigned HALF = 3
) (
  input  wire logic       clk_in,
  input  wire logic [1:0] mode_in,
  output logic            chain_out
);
  import cbta_pkg::*;
  int unsigned cnt_r = 0;
  logic        sq_r  = 1'b0;

  // Free-running square; the real part would also start unaligned
  always @(posedge clk_in)
  begin
    cnt_r <= (cnt_r >= HALF - 1) ? 0 : cnt_r + 1;
    if (cnt_r >= HALF - 1) sq_r <= !sq_r;
  end

  // Role none drives low, static sits high, square toggles
  assign chain_out = (mode_in == ROLE_STATIC) | ((mode_in == ROLE_SQUARE) & sq_r);
endmodule : cbta_upper_dev

/* cbta_cell_balance_fault_tb.sv */
/*
  Self-checking bench for the balance timer and fault block.
  Uses short minute and square counts; the upper neighbour model feeds the chain.
*/
`timescale 1ns/1ps
module cbta_cell_balance_fault_tb;
  import cbta_pkg::*;
  localparam int MIN = 20; // Short minute keeps the run brief
  logic          clk = 1'b0;
  logic          rst_n = 1'b0;
  logic          pin_n = 1'b1;
  logic [1:0]    up_mode = ROLE_NONE;
  cbta_reg_req_t req = '0;
  cbta_conv_t    cv = '0;
  logic          chain;
  logic [7:0]    rdata;
  logic [5:0]    bal;
  logic          fo;
  logic          fd;
  logic          pdn;
  int            n_errors = 0;
  int            total_checks = 0;

  always #4 clk = ~clk;

  cbta_upper_dev #(.HALF(3)) u_up (.clk_in(clk), .mode_in(up_mode), .chain_out(chain));
  cbta_cell_balance_fault #(.MINUTE_CYC(MIN), .SQ100_CYC(10), .SQ1K_CYC(4)) DUT (
    .sys_clk_in(clk), .reset_n_in(rst_n), .reg_req_in(req), .reg_rdata_out(rdata),
    .conv_in(cv), .powerdown_pin_n_in(pin_n), .fault_chain_in(chain),
    .balancing_gate_output_out(bal), .fault_out(fo), .fault_detected_out(fd),
    .powered_down_out(pdn));

  // Bus helpers; each access leaves one idle edge so a request never re-arms in one step
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    tick(1);
    req = '0;
    tick(1);
  endtask : wr
  task automatic rd(input logic [4:0] a, input logic [7:0] exp);
    req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    tick(1);
    req = '0;
    tick(1);
    chk(rdata, exp);
  endtask : rd
  task automatic conv(input logic [1:0] k, input logic [2:0] i, input logic [11:0] d);
    cv = '{valid: 1'b1, kind: k, idx: i, data: d};
    tick(1);
    cv = '0;
    tick(2);
  endtask : conv
  task automatic complete_run();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : complete_run

  // Reset values, including unmapped places
  task automatic t_reset();
    for (int a = 'h0d; a <= 'h1c; a++)
      rd(5'(a), RST_REG8);
    chk({2'h0, bal}, 8'h00);
    chk(8'(fo), 8'h00);
  endtask : t_reset

  // Timer writes saturate at their ceilings
  task automatic t_regs();
    wr(ADDR_BAL_TMR_6, 8'h1f);
    rd(ADDR_BAL_TMR_6, {3'h0, BAL_MAX_MIN});
    wr(ADDR_PWRDN_TMR, 8'hff);
    rd(ADDR_PWRDN_TMR, {3'h0, PWRDN_MAX_MIN});
    wr(ADDR_BAL_TMR_6, 8'h00);
    wr(ADDR_PWRDN_TMR, 8'h00);
  endtask : t_regs

  // Each threshold just crossed, then met exactly
  task automatic t_thresh();
    logic [1:0]  k [4] = '{KIND_VOLT, KIND_VOLT, KIND_TEMP, KIND_TEMP};
    logic [11:0] bad [4] = '{12'h810, 12'h1f0, 12'h910, 12'h2f0};
    logic [11:0] edg [4] = '{12'h800, 12'h200, 12'h900, 12'h300};
    wr(ADDR_OVER_VOLT, 8'h80);
    wr(ADDR_UNDER_VOLT, 8'h20);
    wr(ADDR_OVER_TEMP, 8'h90);
    wr(ADDR_UNDER_TEMP, 8'h30);
    wr(ADDR_FAULT_CFG, 8'h40);
    chk(8'(fo), 8'h01);
    for (int i = 0; i < 4; i++)
    begin
      conv(k[i], 3'(i), bad[i]);
      chk({6'h0, fd, fo}, 8'h02);
      conv(k[i], 3'(i), edg[i]);
      chk({6'h0, fd, fo}, 8'h01);
    end
    rd(ADDR_UNDER_TEMP, 8'h30);
  endtask : t_thresh

  // Every exclusion code against a held fault on each droppable channel
  task automatic t_excl(input logic [1:0] k, input int sh, input logic [2:0] second);
    logic [2:0] ch [2] = '{3'h4, second};
    for (int j = 0; j < 2; j++)
    begin
      conv(k, ch[j], 12'hff0);
      for (int c = 0; c < 4; c++)
      begin
        wr(ADDR_FAULT_CFG, 8'h40 | 8'(c << sh));
        chk(8'(fd), 8'(c != 2 && !(c == 1 && j == 0)));
      end
      conv(k, ch[j], 12'h500);
    end
  endtask : t_excl

  // Self-test level against a raised, then lowered, under-voltage limit
  task automatic t_self();
    up_mode = ROLE_NONE;
    wr(ADDR_UNDER_VOLT, 8'h70);
    conv(KIND_SELFTEST, 3'h0, 12'h600);
    chk(8'(fd), 8'h01);
    wr(ADDR_UNDER_VOLT, 8'h20);
    conv(KIND_SELFTEST, 3'h0, 12'h600);
    chk(8'(fd), 8'h00);
  endtask : t_self

  // Square half periods, then the reserved rate codes stay low
  task automatic t_square();
    logic [7:0] half [2] = '{8'd10, 8'd4};
    int n;
    for (int f = 0; f < 4; f++)
    begin
      wr(ADDR_FAULT_CFG, 8'h80 | 8'(f << 4));
      n = 0;
      while (fo !== 1'b1 && n < 40)
      begin
        tick(1);
        n++;
      end
      n = 0;
      while (fo === 1'b1 && n < 40)
      begin
        tick(1);
        n++;
      end
      chk(8'(n), (f < 2) ? half[f] : 8'd0);
    end
  endtask : t_square

  // Chain pass-through, own fault pulling low, and a silent neighbour
  task automatic t_pass();
    logic last;
    wr(ADDR_FAULT_CFG, 8'hc0);
    up_mode = ROLE_SQUARE;
    repeat (12)
    begin
      last = chain;
      tick(1);
      chk(8'(fo), 8'(last));
    end
    up_mode = ROLE_STATIC;
    conv(KIND_VOLT, 3'h0, 12'hff0);
    chk(8'(fo), 8'h00);
    conv(KIND_VOLT, 3'h0, 12'h500);
    chk(8'(fo), 8'h01);
    up_mode = ROLE_NONE;
    tick(2);
    chk(8'(fo), 8'h00);
  endtask : t_pass

  // Timed balancing stops all outputs; a zero timer has no limit
  task automatic t_bal();
    int n;
    wr(ADDR_BAL_TMR_1 + 5'h1, 8'h02);
    wr(ADDR_BAL_ENABLE, 8'h3f);
    chk({2'h0, bal}, 8'h3f);
    tick(15);
    chk({2'h0, bal}, 8'h3f);
    n = 0;
    while (bal !== 6'h00 && n < MIN + 10)
    begin
      tick(1);
      n++;
    end
    chk({2'h0, bal}, 8'h00);
    wr(ADDR_BAL_TMR_1 + 5'h1, 8'h00);
    wr(ADDR_BAL_ENABLE, 8'h15);
    tick(3 * MIN);
    chk({2'h0, bal}, 8'h15);
  endtask : t_bal

  // Immediate power-down by write and by pin, then a delayed one
  task automatic t_pd();
    int n;
    wr(ADDR_BAL_ENABLE, 8'h3f);
    wr(ADDR_CONTROL_HI, 8'h01);
    chk({1'b0, pdn, bal}, 8'h40);
    wr(ADDR_BAL_ENABLE, 8'h3f);
    chk({2'h0, bal}, 8'h00);
    conv(KIND_VOLT, 3'h0, 12'hff0);
    chk(8'(fd), 8'h00);
    wr(ADDR_CONTROL_HI, 8'h00);
    conv(KIND_VOLT, 3'h6, 12'hff0);
    chk(8'(fd), 8'h00);
    wr(ADDR_BAL_ENABLE, 8'h3f);
    pin_n = 1'b0;
    tick(2);
    chk({1'b0, pdn, bal}, 8'h40);
    pin_n = 1'b1;
    tick(2);
    wr(ADDR_PWRDN_TMR, 8'h02);
    wr(ADDR_BAL_ENABLE, 8'h3f);
    pin_n = 1'b0;
    tick(15);
    chk({1'b0, pdn, bal}, 8'h3f);
    n = 0;
    while (pdn !== 1'b1 && n < MIN + 10)
    begin
      tick(1);
      n++;
    end
    chk({1'b0, pdn, bal}, 8'h40);
    pin_n = 1'b1;
    tick(2);
  endtask : t_pd

  // Main sequence
  initial
  begin
    repeat (2) @(posedge clk);
    #1;
    rst_n = 1'b1;
    t_reset();
    t_regs();
    t_thresh();
    t_excl(KIND_VOLT, 2, 3'h3);
    t_excl(KIND_TEMP, 0, 3'h2);
    t_self();
    t_square();
    t_pass();
    t_bal();
    t_pd();
    complete_run();
  end

  // Watchdog, well beyond the expected run length
  initial
  begin
    #100000;
    n_errors++;
    complete_run();
  end
endmodule : cbta_cell_balance_fault_tb

bind cbta_cell_balance_fault cbta_chk u_chk (
  .sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in), .reg_req_in(reg_req_in),
  .powerdown_pin_n_in(powerdown_pin_n_in), .fault_chain_in(fault_chain_in),
  .balancing_gate_output_out(balancing_gate_output_out), .fault_out(fault_out),
  .fault_detected_out(fault_detected_out), .powered_down_out(powered_down_out));
